// File: src/iotu_defs.vh
// constants for the io timer unit channel
//
// Contract
// [R1] sixteen-bit down counter, reload 0, reload 1 and capture register per channel
// [R2] start by software enable or external input edge or level, selectable; the external start is ignored in measure and noise modes
// [R3] one mode at a time per channel, chosen by mode field
// [R4] measure modes count down after enable; capture copies counter to capture register
// [R5] measure clear: capture also sets counter to all ones
// [R6] measure free-run: count through captures, wrap to all ones on underflow
// [R7] measure modes: event on underflow or capture; stop only by enable clear
// [R8] only the dma capable channel issues dma requests, on underflow
// [R9] noise mode: valid level counts; underflow raises event and stops
// [R10] noise mode: invalid level pauses; valid again reloads initial count, restarts
// [R11] noise mode stops at underflow or enable clear; underflow event and dma
// [R12] pwm: load reload 0 at start, then alternate reload 1 and reload 0
// [R13] pwm output toggles at start and every underflow
// [R14] pwm stops at once when enable cleared
// [R15] pwm interrupt on even underflows only; dma on every underflow
// [R16] single-shot: load reload 0, count, stop at underflow
// [R17] single-shot output toggles at start and underflow; event and dma
// [R18] delayed single-shot: preset count, reload 0 at first underflow, stop at second
// [R19] delayed single-shot toggles at both underflows; event and dma at each
// [R20] mode code 000 ss, 001 dss, 010 cont, 011 pwm, 100 mclr, 101 mfree, 11x noise
// [R21] continuous: preset count, reload 0 each underflow, toggle start and underflows
// [R22] start toggles happen on a count clock enable edge
// [R23] underflow when counter decrements from zero, so n gives n plus one counts
`ifndef IOTU_DEFS_VH
`define IOTU_DEFS_VH
`define IOTU_MODE_SS     3'h0
`define IOTU_MODE_DSS    3'h1
`define IOTU_MODE_CONT   3'h2
`define IOTU_MODE_PWM    3'h3
`define IOTU_MODE_MCLR   3'h4
`define IOTU_MODE_MFREE  3'h5
`define IOTU_TRIG_RISE   3'h0
`define IOTU_TRIG_FALL   3'h1
`define IOTU_TRIG_BOTH   3'h2
`define IOTU_TRIG_HIGH   3'h3
`define IOTU_TRIG_LOW    3'h4
`define IOTU_ADDR_CTRL   3'h0
`define IOTU_ADDR_CNT    3'h1
`define IOTU_ADDR_RLD0   3'h2
`define IOTU_ADDR_RLD1   3'h3
`define IOTU_ADDR_CAP    3'h4
`define IOTU_ADDR_STAT   3'h5
`define IOTU_ADDR_PSC    3'h6
`define IOTU_CTRL_EN     0
`define IOTU_CTRL_EXTEN  1
`define IOTU_CTRL_MODE   4:2
`define IOTU_CTRL_TRIG   7:5
`define IOTU_PSC_RST     16'h0000
`define IOTU_ALL_ONES    16'hffff
`endif

// File: src/iotu_channel.v
// one channel of the sixteen-bit multimode io timer unit
`timescale 1ns/1ps
`include "iotu_defs.vh"
module iotu_channel #(
	parameter DMA_CAPABLE = 1
) (
	input  wire        i_clk,
	input  wire        i_nrst,
	input  wire [2:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output wire [15:0] o_rdata,
	input  wire        i_ext_in,
	input  wire        i_capture,
	output wire        o_pulse,
	output wire        o_irq_evt,
	output wire        o_dma_req,
	output wire        o_running
);
// ============================================================
// input synchronisers
reg [1:0] ext_s_q;
reg [1:0] cap_s_q;
reg       ext_prev_q;
reg       cap_prev_q;
always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		ext_s_q    <= 2'h0;
		cap_s_q    <= 2'h0;
		ext_prev_q <= 1'b0;
		cap_prev_q <= 1'b0;
	end else begin
		ext_s_q    <= {ext_s_q[0], i_ext_in};
		cap_s_q    <= {cap_s_q[0], i_capture};
		ext_prev_q <= ext_s_q[1];
		cap_prev_q <= cap_s_q[1];
	end
end
wire ext_lvl  = ext_s_q[1];
wire ext_rise = ext_lvl & ~ext_prev_q;
wire ext_fall = ~ext_lvl & ext_prev_q;
wire cap_rise = cap_s_q[1] & ~cap_prev_q;
// ============================================================
// registers
reg [7:0]  ctrl_q;
reg [15:0] rld0_q;
reg [15:0] rld1_q;
reg [15:0] cap_q;
reg [15:0] cnt_q;
reg [15:0] psc_q;
reg [15:0] pdiv_q;
reg        run_q;
reg        start_q;
reg        pend_q;
reg        ff_q;
reg        phase_q;
reg        irq_q;
reg        dma_q;
reg        cap_ev_q;
reg        unf_ev_q;
reg [15:0] rdata_q;
wire [2:0] mode  = ctrl_q[`IOTU_CTRL_MODE];
wire [2:0] trig  = ctrl_q[`IOTU_CTRL_TRIG];
wire       noise = mode[2] & mode[1]; // see [R20]
wire       meas  = (mode == `IOTU_MODE_MCLR) | (mode == `IOTU_MODE_MFREE);
wire wr_ctrl = i_wr & (i_addr == `IOTU_ADDR_CTRL);
wire wr_en1  = wr_ctrl & i_wdata[`IOTU_CTRL_EN];
wire wr_en0  = wr_ctrl & ~i_wdata[`IOTU_CTRL_EN];
// ============================================================
// count clock prescaler: one-cycle enable pulse
// compare with >= so a smaller divider written mid-count cannot run the count to a wrap
wire tick = (pdiv_q >= psc_q);
always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		pdiv_q <= 16'h0000;
	end else if (tick) begin
		pdiv_q <= 16'h0000;
	end else begin
		pdiv_q <= pdiv_q + 16'h0001;
	end
end
// ============================================================
// external start condition
reg ext_go;
always @* begin
	case (trig)
		`IOTU_TRIG_RISE: ext_go = ext_rise;
		`IOTU_TRIG_FALL: ext_go = ext_fall;
		`IOTU_TRIG_BOTH: ext_go = ext_rise | ext_fall;
		`IOTU_TRIG_HIGH: ext_go = ext_lvl;
		`IOTU_TRIG_LOW:  ext_go = ~ext_lvl;
		default:         ext_go = 1'b0;
	endcase
end
// noise mode valid level, polarity from the level trigger choice
wire valid_lvl = (trig == `IOTU_TRIG_LOW) ? ~ext_lvl : ext_lvl;
// external start only when enabled; noise mode runs from the level itself
wire ext_start = ctrl_q[`IOTU_CTRL_EXTEN] & ext_go & ~noise & ~meas; // see [R2]
// ============================================================
// counter and mode sequencing
wire unf = run_q & tick & (cnt_q == 16'h0000) & ~start_q; // see [R23]
always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		ctrl_q   <= 8'h00;
		rld0_q   <= 16'h0000;
		rld1_q   <= 16'h0000;
		cap_q    <= 16'h0000;
		cnt_q    <= 16'h0000;
		psc_q    <= `IOTU_PSC_RST;
		run_q    <= 1'b0;
		start_q  <= 1'b0;
		pend_q   <= 1'b0;
		ff_q     <= 1'b0;
		phase_q  <= 1'b0;
		irq_q    <= 1'b0;
		dma_q    <= 1'b0;
		cap_ev_q <= 1'b0;
		unf_ev_q <= 1'b0;
	end else begin
		irq_q <= 1'b0;
		dma_q <= 1'b0;
		if (wr_ctrl) begin
			ctrl_q <= i_wdata[7:0]; // see [R3]
		end
		if (i_wr & (i_addr == `IOTU_ADDR_RLD0)) begin
			rld0_q <= i_wdata;
		end
		if (i_wr & (i_addr == `IOTU_ADDR_RLD1)) begin
			rld1_q <= i_wdata;
		end
		if (i_wr & (i_addr == `IOTU_ADDR_PSC)) begin
			psc_q <= i_wdata;
		end
		if (i_wr & (i_addr == `IOTU_ADDR_CNT)) begin
			cnt_q <= i_wdata;
		end
		// sticky status, set wins over the read clear
		if (i_rd & (i_addr == `IOTU_ADDR_STAT)) begin
			cap_ev_q <= 1'b0;
			unf_ev_q <= 1'b0;
		end
		// software disable beats any start in the same cycle
		if (wr_en0) begin
			run_q  <= 1'b0; // see [R14]
			pend_q <= 1'b0;
			start_q <= 1'b0;
		end else if ((wr_en1 | ext_start) & ~run_q & ~pend_q) begin
			pend_q <= 1'b1;
		end
		// start waits for the count clock so the toggle lands on it
		if (pend_q & tick & ~wr_en0) begin // see [R22]
			pend_q  <= 1'b0;
			run_q   <= 1'b1;
			phase_q <= 1'b0;
			case (mode)
				`IOTU_MODE_SS, `IOTU_MODE_PWM: begin
					cnt_q <= rld0_q; // see [R12] [R16]
					ff_q  <= ~ff_q; // see [R13] [R17]
				end
				`IOTU_MODE_CONT: begin
					cnt_q <= cnt_q - 16'h0001;
					ff_q  <= ~ff_q; // see [R21]
				end
				`IOTU_MODE_MCLR, `IOTU_MODE_MFREE: begin
					cnt_q <= cnt_q - 16'h0001; // see [R4]
				end
				`IOTU_MODE_DSS: begin
					cnt_q <= cnt_q - 16'h0001; // see [R18]
				end
				default: begin
					cnt_q <= rld0_q;
					start_q <= 1'b1;
				end
			endcase
		end else if (run_q & ~wr_en0 & noise) begin
			// noise: rld0 holds the initial count
			if (~valid_lvl) begin
				start_q <= 1'b1; // see [R10]
			end else if (tick) begin
				if (start_q) begin
					cnt_q   <= rld0_q; // see [R10]
					start_q <= 1'b0;
				end else if (cnt_q == 16'h0000) begin
					run_q    <= 1'b0; // see [R9] [R11]
					irq_q    <= 1'b1;
					dma_q    <= (DMA_CAPABLE != 0); // see [R8]
					unf_ev_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end else if (run_q & ~wr_en0 & tick) begin
			if (unf) begin
				unf_ev_q <= 1'b1;
				dma_q    <= (DMA_CAPABLE != 0); // see [R8]
				case (mode)
					`IOTU_MODE_SS: begin
						run_q <= 1'b0; // see [R16]
						ff_q  <= ~ff_q; // see [R17]
						irq_q <= 1'b1;
						cnt_q <= `IOTU_ALL_ONES;
					end
					`IOTU_MODE_DSS: begin
						ff_q  <= ~ff_q; // see [R19]
						irq_q <= 1'b1;
						phase_q <= 1'b1;
						if (phase_q) begin
							run_q <= 1'b0; // see [R18]
							cnt_q <= `IOTU_ALL_ONES;
						end else begin
							cnt_q <= rld0_q;
						end
					end
					`IOTU_MODE_CONT: begin
						ff_q  <= ~ff_q; // see [R21]
						irq_q <= 1'b1;
						cnt_q <= rld0_q;
					end
					`IOTU_MODE_PWM: begin
						ff_q    <= ~ff_q; // see [R13]
						phase_q <= ~phase_q;
						irq_q   <= phase_q; // see [R15]
						cnt_q   <= phase_q ? rld0_q : rld1_q; // see [R12]
					end
					default: begin
						irq_q <= 1'b1; // see [R7]
						cnt_q <= `IOTU_ALL_ONES; // see [R6]
					end
				endcase
			end else begin
				cnt_q <= cnt_q - 16'h0001; // see [R1]
			end
		end
		// capture in measure modes, independent of the count clock
		if (run_q & meas & cap_rise & ~wr_en0) begin
			cap_q    <= cnt_q; // see [R4]
			cap_ev_q <= 1'b1;
			irq_q    <= 1'b1; // see [R7]
			if (mode == `IOTU_MODE_MCLR) begin
				cnt_q <= `IOTU_ALL_ONES; // see [R5]
			end
		end
	end
end
// ============================================================
// read port, data one cycle after the strobe
always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		rdata_q <= 16'h0000;
	end else if (i_rd) begin
		case (i_addr)
			`IOTU_ADDR_CTRL: rdata_q <= {8'h00, ctrl_q[7:1], run_q};
			`IOTU_ADDR_CNT:  rdata_q <= cnt_q;
			`IOTU_ADDR_RLD0: rdata_q <= rld0_q;
			`IOTU_ADDR_RLD1: rdata_q <= rld1_q;
			`IOTU_ADDR_CAP:  rdata_q <= cap_q;
			`IOTU_ADDR_STAT: rdata_q <= {12'h000, ff_q, run_q, cap_ev_q, unf_ev_q};
			`IOTU_ADDR_PSC:  rdata_q <= psc_q;
			default:         rdata_q <= 16'h0000;
		endcase
	end else begin
		rdata_q <= 16'h0000;
	end
end
assign o_rdata   = rdata_q;
assign o_pulse   = ff_q;
assign o_irq_evt = irq_q;
assign o_dma_req = dma_q;
assign o_running = run_q;
endmodule // iotu_channel

// File: tb/iotu_monitor.sv
// checker for one io timer unit channel
`timescale 1ns/1ps
module iotu_monitor (
	input wire        i_clk,
	input wire        i_nrst,
	input wire [2:0]  i_addr,
	input wire [15:0] i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [15:0] o_rdata,
	input wire        i_ext_in,
	input wire        i_capture,
	input wire        o_pulse,
	input wire        o_irq_evt,
	input wire        o_dma_req,
	input wire        o_running
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// ====================
	// control writes
	sequence ctl_wr;
		i_wr && i_addr == 3'h0;
	endsequence
	sequence go_wr;
		ctl_wr ##0 (i_wdata[0] && !o_running);
	endsequence
	sequence stop_wr;
		ctl_wr ##0 !i_wdata[0];
	endsequence
	// ====================
	// properties
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("rdata idle");
	rd_unmap_a: assert property ($past(i_rd && i_addr == 3'h7) |-> o_rdata == 16'h0000) else $error("rd7");
	start_run_a: assert property (go_wr |-> ##[1:3] o_running) else $error("no start");
	stop_now_a: assert property (stop_wr |=> !o_running) else $error("no stop");
	dma_one_a: assert property (o_dma_req |=> !o_dma_req) else $error("dma long");
	dma_run_a: assert property (o_dma_req |-> $past(o_running) || $past(o_running, 2)) else $error("dma idle");
	irq_run_a: assert property (o_irq_evt |-> $past(o_running) || $past(o_running, 2)) else $error("irq idle");
	tgl_run_a: assert property ($changed(o_pulse) |-> o_running || $past(o_running)) else $error("ff idle");
endmodule // iotu_monitor
bind iotu_channel iotu_monitor mon (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_in(i_ext_in),
	.i_capture(i_capture), .o_pulse(o_pulse), .o_irq_evt(o_irq_evt),
	.o_dma_req(o_dma_req), .o_running(o_running));

// File: tb/iotu_far_end.sv
// far side model: enable or noise level and capture strobe
`timescale 1ns/1ps
module iotu_far_end (
	input  wire  i_clk,
	output logic o_ext,
	output logic o_cap
);
	initial begin
		o_ext = 1'b0;
		o_cap = 1'b0;
	end
	// valid level for n cycles, then back low
	task automatic ext_pulse(input int n);
		@(posedge i_clk) o_ext <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_ext <= 1'b0;
	endtask
	// held past the input synchroniser so the edge is not lost
	task automatic cap_pulse();
		@(posedge i_clk) o_cap <= 1'b1;
		repeat (3) @(posedge i_clk);
		o_cap <= 1'b0;
	endtask
endmodule // iotu_far_end

// File: tb/tb_top.sv
// self-checking bench for one io timer unit channel
`timescale 1ns/1ps
`include "iotu_defs.vh"
module tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] irq_n = 16'h0000, dma_n = 16'h0000, i0, d0;
	wire  [15:0] rdata;
	wire         ext, cap, pulse, irq, dma, run;
	int          fails = 0, checks = 0, n;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		irq_n <= irq_n + {15'h0000, irq === 1'b1};
		dma_n <= dma_n + {15'h0000, dma === 1'b1};
	end
	iotu_channel uut (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_in(ext), .i_capture(cap),
		.o_pulse(pulse), .o_irq_evt(irq), .o_dma_req(dma), .o_running(run));
	iotu_far_end far (.i_clk(clk), .o_ext(ext), .o_cap(cap));
	// ====================
	// helpers
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wrr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk) begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
		end
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rdm(input logic [2:0] a, input logic [15:0] m, e);
		@(posedge clk) begin
			addr <= a;
			rd <= 1'b1;
		end
		@(posedge clk) rd <= 1'b0;
		#1 cmp(rdata & m, e);
	endtask
	task automatic go(input logic [2:0] m);
		i0 = irq_n;
		d0 = dma_n;
		wrr(3'h0, {11'h000, m, 2'b01});
	endtask
	task automatic evts(input logic [15:0] ei, ed);
		repeat (3) @(posedge clk);
		#1 cmp(irq_n - i0, ei);
		cmp(dma_n - d0, ed);
	endtask
	// a bounded wait, so a dead output ends the run with a verdict
	task automatic tgl();
		logic p;
		#1 p = pulse;
		n = 0;
		while (pulse === p) begin
			@(posedge clk) #1 n++;
			if (n > 2000) begin
				fails++;
				tally_and_finish();
			end
		end
	endtask
	// ====================
	// scenarios
	task automatic t_regs();
		for (int a = 0; a < 8; a++) rdm(a[2:0], 16'hffff, 16'h0000);
		wrr(3'h7, 16'hffff);
		rdm(3'h7, 16'hffff, 16'h0000);
		$display("test regs done");
	endtask
	task automatic t_ss();
		wrr(3'h2, 16'h0003);
		go(`IOTU_MODE_SS);
		tgl();
		tgl();
		cmp(n[15:0], 16'h0004);
		evts(16'h0001, 16'h0001);
		cmp({15'h0000, run}, 16'h0000);
		rdm(3'h5, 16'h000f, 16'h0001);
		rdm(3'h5, 16'h000f, 16'h0000);
		$display("test single shot done");
	endtask
	task automatic t_pwm();
		wrr(3'h2, 16'h0002);
		wrr(3'h3, 16'h0004);
		go(`IOTU_MODE_PWM);
		tgl();
		for (int k = 0; k < 4; k++) begin
			tgl();
			cmp(n[15:0], k[0] ? 16'h0005 : 16'h0003);
		end
		wrr(3'h0, 16'h0000);
		#1 cmp({15'h0000, run}, 16'h0000);
		evts(16'h0002, 16'h0004);
		$display("test pwm done");
	endtask
	task automatic t_dss();
		wrr(3'h1, 16'h0003);
		wrr(3'h2, 16'h0002);
		go(`IOTU_MODE_DSS);
		tgl();
		cmp(n[15:0], 16'h0004);
		tgl();
		cmp(n[15:0], 16'h0003);
		evts(16'h0002, 16'h0002);
		cmp({15'h0000, run}, 16'h0000);
		$display("test delayed shot done");
	endtask
	task automatic t_cont();
		wrr(3'h1, 16'h0002);
		wrr(3'h2, 16'h0003);
		go(`IOTU_MODE_CONT);
		tgl();
		tgl();
		tgl();
		cmp(n[15:0], 16'h0004);
		tgl();
		cmp(n[15:0], 16'h0004);
		wrr(3'h0, 16'h0000);
		$display("test continuous done");
	endtask
	task automatic t_meas(input logic [2:0] m, input logic [15:0] top);
		wrr(3'h1, 16'h0100);
		go(m);
		repeat (10) @(posedge clk);
		far.cap_pulse();
		repeat (6) @(posedge clk);
		rdm(3'h4, 16'hff00, 16'h0000);
		rdm(3'h5, 16'h0006, 16'h0006);
		rdm(3'h1, 16'hf000, top);
		evts(16'h0001, 16'h0000);
		wrr(3'h0, 16'h0000);
		#1 cmp({15'h0000, run}, 16'h0000);
		$display("test measure done");
	endtask
	task automatic t_noise();
		wrr(3'h2, 16'h0005);
		i0 = irq_n;
		d0 = dma_n;
		wrr(3'h0, 16'h007d);
		far.ext_pulse(3);
		repeat (10) @(posedge clk);
		#1 cmp(irq_n - i0, 16'h0000);
		cmp({15'h0000, run}, 16'h0001);
		far.ext_pulse(20);
		evts(16'h0001, 16'h0001);
		cmp({15'h0000, run}, 16'h0000);
		$display("test noise done");
	endtask
	task automatic t_ext();
		wrr(3'h2, 16'h0003);
		i0 = irq_n;
		d0 = dma_n;
		wrr(3'h0, 16'h0002);
		repeat (5) @(posedge clk);
		#1 cmp({15'h0000, run}, 16'h0000);
		far.ext_pulse(8);
		evts(16'h0001, 16'h0001);
		wrr(3'h0, 16'h0000);
		$display("test external start done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_ss();
		t_pwm();
		t_dss();
		t_cont();
		t_meas(`IOTU_MODE_MCLR, 16'hf000);
		t_meas(`IOTU_MODE_MFREE, 16'h0000);
		t_noise();
		t_ext();
		tally_and_finish();
	end
endmodule // tb_top
